// >>> logic/slc_cmd_if.v
// host command and data register interface of the serial link master
`include "slc_consts.vh"
// Behaviour
// - command is 16 bits in low word
// - bit 15 marks a parameter write
// - bit 14 holds processor reset
// - bit 13 requests local parameter access
// - bit 12 is masked process transfer
// - bit11 plus type: stop, start, setup start
// - low byte mask selects channels
// - write starts command; zero marks completion
// - pending command reads back as written
// - stop-all accepted anytime, resets interface
// - command writes with bit 31 set are discarded
// - 8-bit data register, right aligned
// - command, data and thirty-two per-channel registers
// - start result mask marks failed channels
// - transfer result mask flags failed channels
module slc_cmd_if (
  input wire clk,
  input wire resetn,
  input wire host_wr,
  input wire host_rd,
  input wire [5:0] host_addr,
  input wire [31:0] host_wdata,
  output reg [31:0] host_rdata_ff,
  output reg proc_reset_ff,
  output reg link_start_ff,
  output reg link_setup_ff,
  output reg link_stop_ff,
  output reg link_stop_all_ff,
  output reg link_xfer_ff,
  output reg [7:0] link_mask_ff,
  input wire link_done,
  input wire [7:0] link_fail,
  output reg [7:0] chan_active_ff,
  input wire link_reg_we,
  input wire [4:0] link_reg_addr,
  input wire [31:0] link_reg_wdata,
  output reg [31:0] link_reg_rdata_ff
);
  localparam ST_IDLE = 2'h0;
  localparam ST_LINK = 2'h1;
  localparam ST_PARAM = 2'h2;
  localparam ST_HOLD = 2'h3;

  reg [15:0] cmd_ff;
  reg [7:0] data_ff;
  reg [1:0] state_ff;
  reg is_start_ff;
  reg [31:0] chan_regs [0:31];
  reg [1:0] nxt_state;
  reg [15:0] nxt_cmd;
  reg [7:0] nxt_data;
  reg [7:0] nxt_active;
  reg nxt_is_start;
  reg nxt_start;
  reg nxt_setup;
  reg nxt_stop;
  reg nxt_stop_all;
  reg nxt_xfer;
  reg [7:0] nxt_mask;
  wire [7:0] rom_q;
  wire cmd_wr;
  wire data_wr;
  wire chan_sel;
  wire [15:0] wcmd;
  wire [2:0] wtype;
  wire is_stop_all;
  wire wr_allowed;

  slc_param_rom u_rom (
    .clk(clk),
    .resetn(resetn),
    // the table looks up the word being loaded so its byte is ready one edge later
    .addr(nxt_cmd[`SLC_PADDR_HI:0]),
    .q_ff(rom_q)
  );

  assign wcmd = host_wdata[15:0];
  assign wtype = wcmd[`SLC_TYPE_HI:`SLC_TYPE_LO];
  assign is_stop_all = (wcmd == `SLC_CMD_STOPALL);
  // a write while busy is refused except stop-all; a held processor reset
  // stays writable so the host can release it
  assign wr_allowed = (cmd_ff == `SLC_CMD_RESET) || is_stop_all
    || (state_ff == ST_HOLD);
  assign cmd_wr = host_wr && (host_addr == `SLC_REG_CMD)
    && !host_wdata[`SLC_BIT_IGNORE] && wr_allowed;
  assign data_wr = host_wr && (host_addr == `SLC_REG_DATA);
  assign chan_sel = ((host_addr & `SLC_REG_CHAN_BASE) == `SLC_REG_CHAN_BASE);

  always @* begin
    nxt_state = state_ff;
    nxt_cmd = cmd_ff;
    nxt_data = data_ff;
    nxt_active = chan_active_ff;
    nxt_is_start = is_start_ff;
    nxt_start = 1'b0;
    nxt_setup = link_setup_ff;
    nxt_stop = 1'b0;
    nxt_stop_all = 1'b0;
    nxt_xfer = 1'b0;
    nxt_mask = link_mask_ff;
    if (data_wr) begin
      nxt_data = host_wdata[7:0];
    end
    case (state_ff)
      ST_LINK: begin
        if (link_done) begin
          nxt_data = link_fail;
          if (is_start_ff) begin
            nxt_active = chan_active_ff | (link_mask_ff & ~link_fail);
          end
          nxt_cmd = `SLC_CMD_RESET;
          nxt_state = ST_IDLE;
        end
      end
      ST_PARAM: begin
        // table byte was registered from the command word at the write edge
        nxt_data = rom_q;
        nxt_cmd = `SLC_CMD_RESET;
        nxt_state = ST_IDLE;
      end
      ST_HOLD: begin
        nxt_state = ST_HOLD;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (cmd_wr) begin
      nxt_cmd = wcmd;
      nxt_mask = wcmd[`SLC_MASK_HI:`SLC_MASK_LO];
      nxt_is_start = 1'b0;
      if (is_stop_all) begin
        // aborts any pending operation and forgets every channel
        nxt_active = 8'h00;
        nxt_stop_all = 1'b1;
        nxt_cmd = `SLC_CMD_RESET;
        nxt_data = `SLC_DATA_RESET;
        nxt_state = ST_IDLE;
      end else if (wcmd[`SLC_BIT_ROMRST]) begin
        nxt_state = ST_HOLD;
      end else if (wcmd[`SLC_BIT_REQ]) begin
        // a parameter write (bit 15) lands on read-only entries and only completes
        nxt_state = wcmd[`SLC_BIT_WRITE] ? ST_IDLE : ST_PARAM;
        if (wcmd[`SLC_BIT_WRITE]) begin
          nxt_cmd = `SLC_CMD_RESET;
        end
      end else if (wcmd[`SLC_BIT_XFER]) begin
        nxt_xfer = 1'b1;
        nxt_state = ST_LINK;
      end else if (wcmd[`SLC_BIT_STARTSTOP] && wtype == `SLC_TYPE_STOP) begin
        nxt_stop = 1'b1;
        nxt_active = chan_active_ff & ~wcmd[`SLC_MASK_HI:`SLC_MASK_LO];
        nxt_cmd = `SLC_CMD_RESET;
        nxt_state = ST_IDLE;
      end else if (wcmd[`SLC_BIT_STARTSTOP]
          && (wtype == `SLC_TYPE_START || wtype == `SLC_TYPE_SETUP)) begin
        nxt_start = 1'b1;
        nxt_setup = (wtype == `SLC_TYPE_SETUP);
        nxt_is_start = 1'b1;
        nxt_state = ST_LINK;
      end else begin
        // zero or undecoded commands complete at once
        nxt_cmd = `SLC_CMD_RESET;
        nxt_state = ST_IDLE;
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      cmd_ff <= `SLC_CMD_RESET;
      data_ff <= `SLC_DATA_RESET;
      state_ff <= ST_IDLE;
      is_start_ff <= 1'b0;
      chan_active_ff <= 8'h00;
      proc_reset_ff <= 1'b0;
      link_start_ff <= 1'b0;
      link_setup_ff <= 1'b0;
      link_stop_ff <= 1'b0;
      link_stop_all_ff <= 1'b0;
      link_xfer_ff <= 1'b0;
      link_mask_ff <= 8'h00;
    end else begin
      cmd_ff <= nxt_cmd;
      data_ff <= nxt_data;
      state_ff <= nxt_state;
      is_start_ff <= nxt_is_start;
      chan_active_ff <= nxt_active;
      proc_reset_ff <= (nxt_state == ST_HOLD);
      link_start_ff <= nxt_start;
      link_setup_ff <= nxt_setup;
      link_stop_ff <= nxt_stop;
      link_stop_all_ff <= nxt_stop_all;
      link_xfer_ff <= nxt_xfer;
      link_mask_ff <= nxt_mask;
    end
  end

  // per-channel registers: a host write wins and drops any link write in the same cycle, whatever its word
  always @(posedge clk) begin
    if (host_wr && chan_sel) begin
      chan_regs[host_addr[4:0]] <= host_wdata;
    end else if (link_reg_we) begin
      chan_regs[link_reg_addr] <= link_reg_wdata;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      host_rdata_ff <= 32'h00000000;
      link_reg_rdata_ff <= 32'h00000000;
    end else begin
      link_reg_rdata_ff <= chan_regs[link_reg_addr];
      if (host_rd) begin
        if (host_addr == `SLC_REG_CMD) begin
          host_rdata_ff <= {16'h0000, cmd_ff};
        end else if (host_addr == `SLC_REG_DATA) begin
          host_rdata_ff <= {24'h000000, data_ff};
        end else if (chan_sel) begin
          host_rdata_ff <= chan_regs[host_addr[4:0]];
        end else begin
          host_rdata_ff <= 32'h00000000;
        end
      end
    end
  end
endmodule

// >>> logic/slc_consts.vh
// constants for the serial link command interface
`ifndef SLC_CONSTS_VH
`define SLC_CONSTS_VH
// host register word indices (host_addr)
`define SLC_ADDR_W 6
`define SLC_REG_CMD 6'h00
`define SLC_REG_DATA 6'h01
`define SLC_REG_CHAN_BASE 6'h20
// command field positions
`define SLC_BIT_IGNORE 31
`define SLC_BIT_WRITE 15
`define SLC_BIT_ROMRST 14
`define SLC_BIT_REQ 13
`define SLC_BIT_XFER 12
`define SLC_BIT_STARTSTOP 11
`define SLC_TYPE_HI 10
`define SLC_TYPE_LO 8
`define SLC_MASK_HI 7
`define SLC_MASK_LO 0
`define SLC_PADDR_HI 10
// start/stop type codes and whole-word stop-all
`define SLC_TYPE_STOP 3'h0
`define SLC_TYPE_START 3'h1
`define SLC_TYPE_SETUP 3'h7
`define SLC_CMD_STOPALL 16'h0800
// reset values
`define SLC_CMD_RESET 16'h0000
`define SLC_DATA_RESET 8'h00
// local parameter table
`define SLC_PAR_IF_TYPE 8'h12
`define SLC_PAR_IF_WIDTH 8'h08
`define SLC_PAR_GP_IN 8'h00
`define SLC_PAR_GP_OUT 8'h00
`define SLC_PAR_CHANNELS 8'h08
`define SLC_NUM_PARAMS 11'h008
`endif

// >>> logic/slc_param_rom.v
// read-only local parameter table of the command interface
`include "slc_consts.vh"
module slc_param_rom #(
  parameter [7:0] MAJOR_REV = 8'h01,
  parameter [7:0] MINOR_REV = 8'h00,
  // arbitrary processor type code
  parameter [7:0] PROC_TYPE = 8'h5a
) (
  input wire clk,
  input wire resetn,
  input wire [10:0] addr,
  output reg [7:0] q_ff
);
  reg [7:0] nxt_q;
  always @* begin
    case (addr)
      11'h000: nxt_q = `SLC_PAR_IF_TYPE;
      11'h001: nxt_q = `SLC_PAR_IF_WIDTH;
      11'h002: nxt_q = MAJOR_REV;
      11'h003: nxt_q = MINOR_REV;
      11'h004: nxt_q = `SLC_PAR_GP_IN;
      11'h005: nxt_q = `SLC_PAR_GP_OUT;
      11'h006: nxt_q = PROC_TYPE;
      11'h007: nxt_q = `SLC_PAR_CHANNELS;
      // unmapped parameter addresses read as zero
      default: nxt_q = 8'h00;
    endcase
  end
  always @(posedge clk) begin
    if (!resetn) begin
      q_ff <= 8'h00;
    end else begin
      q_ff <= nxt_q;
    end
  end
endmodule

// >>> testbench/slc_cmd_props.sv
// port assertions of the command interface
module slc_cmd_props (
  input wire clk,
  input wire resetn,
  input wire host_wr,
  input wire host_rd,
  input wire [5:0] host_addr,
  input wire [31:0] host_wdata,
  input wire [31:0] host_rdata_ff,
  input wire link_start_ff,
  input wire link_setup_ff,
  input wire link_stop_ff,
  input wire link_stop_all_ff,
  input wire link_xfer_ff,
  input wire [7:0] link_mask_ff,
  input wire [7:0] chan_active_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_cmd_wr;
    host_wr && host_addr == 6'h00 && !host_wdata[31];
  endsequence
  sequence s_any_pulse;
    link_start_ff || link_stop_ff || link_stop_all_ff || link_xfer_ff;
  endsequence
  a_stop_all_now: assert property (s_cmd_wr ##0 host_wdata[15:0] == 16'h0800
    |=> link_stop_all_ff && chan_active_ff == 8'h00) else $error("stop-all not taken");
  a_ignore_bit_write: assert property (host_wr && host_addr == 6'h00 && host_wdata[31]
    |=> not s_any_pulse) else $error("ignored write acted");
  a_start_one_cycle: assert property (link_start_ff |=> !link_start_ff)
    else $error("start pulse too long");
  a_xfer_cause: assert property ($rose(link_xfer_ff)
    |-> $past(host_wr) && $past(host_wdata[12])) else $error("transfer without command");
  a_start_mask: assert property (link_start_ff
    |-> link_mask_ff == $past(host_wdata[7:0])) else $error("start mask wrong");
  a_setup_mode: assert property (link_start_ff
    |-> link_setup_ff == ($past(host_wdata[10:8]) == 3'h7)) else $error("setup mode wrong");
  a_cmd_upper_zero: assert property (host_rd && host_addr == 6'h00
    |=> host_rdata_ff[31:16] == 16'h0) else $error("command upper bits set");
  a_data_upper_zero: assert property (host_rd && host_addr == 6'h01
    |=> host_rdata_ff[31:8] == 24'h0) else $error("data upper bits set");
  a_stop_clears: assert property (link_stop_ff
    |-> (chan_active_ff & link_mask_ff) == 8'h00) else $error("stopped channel active");
  a_reset_idle: assert property (disable iff (1'b0) !resetn
    |=> chan_active_ff == 8'h00) else $error("channels active after reset");
endmodule

// >>> testbench/slc_host_model.sv
// host driver model for the command and data registers
module slc_host_model (
  input wire clk,
  output logic host_wr,
  output logic host_rd,
  output logic [5:0] host_addr,
  output logic [31:0] host_wdata,
  input wire [31:0] host_rdata_ff
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_addr = 6'h00;
    host_wdata = 32'h0;
  end
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    host_wr <= 1'b1;
    host_addr <= a;
    host_wdata <= d;
    @(posedge clk);
    host_wr <= 1'b0;
    // released data shows the inverse so stale values cannot pass
    host_wdata <= ~d;
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk);
    host_rd <= 1'b1;
    host_addr <= a;
    @(posedge clk);
    host_rd <= 1'b0;
    #1 d = host_rdata_ff;
  endtask
  // writes wait for zero; bounded so a stuck command cannot hang
  task automatic poll(output logic [31:0] v);
    int n;
    v = 32'h1;
    for (n = 0; n < 64 && v !== 32'h0; n++) rd(6'h00, v);
  endtask
endmodule

// >>> testbench/slc_cmd_if_bench.sv
// testbench of the serial link command interface
module slc_cmd_if_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, resetn = 1'b0, link_done = 1'b0;
  logic host_wr, host_rd, proc_reset_ff, link_start_ff, link_setup_ff;
  logic link_stop_ff, link_stop_all_ff, link_xfer_ff;
  logic [5:0] host_addr;
  logic [31:0] host_wdata, host_rdata_ff, v;
  logic [7:0] link_fail = 8'h00, link_mask_ff, chan_active_ff;
  logic link_reg_we = 1'b0;
  logic [31:0] link_reg_wdata = 32'h0, link_reg_rdata_ff;
  int err_count = 0, n_tests = 0, cyc = 0;
  initial forever #50 clk = ~clk;
  slc_host_model host_u (.clk(clk), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata_ff(host_rdata_ff));
  slc_cmd_if dut_u (.clk(clk), .resetn(resetn), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata_ff(host_rdata_ff),
    .proc_reset_ff(proc_reset_ff), .link_start_ff(link_start_ff), .link_setup_ff(link_setup_ff),
    .link_stop_ff(link_stop_ff), .link_stop_all_ff(link_stop_all_ff),
    .link_xfer_ff(link_xfer_ff), .link_mask_ff(link_mask_ff), .link_done(link_done),
    .link_fail(link_fail), .chan_active_ff(chan_active_ff), .link_reg_we(link_reg_we),
    .link_reg_addr(5'h03), .link_reg_wdata(link_reg_wdata),
    .link_reg_rdata_ff(link_reg_rdata_ff));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic link_end(input logic [7:0] f);
    repeat (3) @(posedge clk);
    link_done <= 1'b1;
    link_fail <= f;
    @(posedge clk);
    link_done <= 1'b0;
    link_fail <= ~f;
  endtask
  task automatic t_reset;
    host_u.rd(6'h00, v);
    chk("command", 32'h0, v);
    host_u.rd(6'h01, v);
    chk("data", 32'h0, v);
  endtask
  task automatic t_chan;
    host_u.wr(6'h23, 32'ha5a5_0001);
    host_u.rd(6'h23, v);
    chk("channel reg", 32'ha5a5_0001, v);
    chk("link side reg", 32'ha5a5_0001, link_reg_rdata_ff);
    @(posedge clk);
    link_reg_we <= 1'b1;
    link_reg_wdata <= 32'h0000_5a5a;
    @(posedge clk);
    link_reg_we <= 1'b0;
    host_u.rd(6'h23, v);
    chk("link write", 32'h0000_5a5a, v);
  endtask
  task automatic t_start;
    host_u.wr(6'h00, 32'h0903);
    host_u.rd(6'h00, v);
    chk("pending", 32'h0903, v);
    host_u.wr(6'h00, 32'h8000_0000);
    host_u.rd(6'h00, v);
    chk("ignored", 32'h0903, v);
    link_end(8'h02);
    host_u.poll(v);
    chk("cleared", 32'h0, v);
    host_u.rd(6'h01, v);
    chk("start fail", 32'h02, v);
    chk("active", 32'h01, {24'h0, chan_active_ff});
  endtask
  task automatic t_xfer;
    int i;
    for (i = 0; i < 2; i++) begin
      host_u.wr(6'h00, 32'h1001);
      link_end(i ? 8'h00 : 8'h01);
      host_u.poll(v);
      chk("xfer done", 32'h0, v);
      host_u.rd(6'h01, v);
      chk("xfer result", i ? 32'h0 : 32'h01, v);
    end
  endtask
  task automatic t_stop;
    host_u.wr(6'h00, 32'h0801);
    host_u.poll(v);
    chk("stopped", 32'h0, {24'h0, chan_active_ff});
    host_u.wr(6'h00, 32'h0f06);
    host_u.rd(6'h00, v);
    chk("setup", 32'h1, {31'h0, link_setup_ff});
    host_u.wr(6'h00, 32'h0800);
    host_u.poll(v);
    chk("stop-all", 32'h0, v);
    host_u.rd(6'h01, v);
    chk("stop-all data", 32'h0, v);
  endtask
  task automatic t_param;
    int i;
    for (i = 0; i < 2; i++) begin
      host_u.wr(6'h00, 32'h2000 | i);
      host_u.poll(v);
      chk("param done", 32'h0, v);
      host_u.rd(6'h01, v);
      chk("parameter", i ? 32'h08 : 32'h12, v);
    end
    host_u.wr(6'h01, 32'h55);
    host_u.wr(6'h00, 32'ha001);
    host_u.poll(v);
    chk("param write", 32'h0, v);
    host_u.rd(6'h01, v);
    chk("param data held", 32'h55, v);
  endtask
  task automatic t_proc;
    host_u.wr(6'h00, 32'h4000);
    host_u.rd(6'h00, v);
    chk("proc held", 32'h4000, v);
    chk("proc reset", 32'h1, {31'h0, proc_reset_ff});
    host_u.wr(6'h00, 32'h0);
    host_u.rd(6'h00, v);
    chk("proc free", 32'h0, {31'h0, proc_reset_ff});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_chan();
    t_start();
    t_xfer();
    t_stop();
    t_param();
    t_proc();
    test_done();
  end
endmodule
bind slc_cmd_if slc_cmd_props props_u (.clk(clk), .resetn(resetn), .host_wr(host_wr),
  .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
  .host_rdata_ff(host_rdata_ff), .link_start_ff(link_start_ff), .link_setup_ff(link_setup_ff),
  .link_stop_ff(link_stop_ff), .link_stop_all_ff(link_stop_all_ff),
  .link_xfer_ff(link_xfer_ff), .link_mask_ff(link_mask_ff), .chan_active_ff(chan_active_ff));
